// >>> verilog/hat_consts.svh
// Register indices, field positions, reset values and timing counts of the angle converter.
`ifndef HAT_CONSTS_SVH
`define HAT_CONSTS_SVH
`define HAT_IDX_CFG       6'h00
`define HAT_IDX_RES       6'h01
`define HAT_IDX_CUT       6'h04
`define HAT_IDX_HRM_HI    6'h05
`define HAT_IDX_HRM_LO    6'h06
`define HAT_IDX_OFS_MT3   6'h0D
`define HAT_IDX_OFS_MT2   6'h0E
`define HAT_IDX_OFS_MT1   6'h0F
`define HAT_IDX_OFS_MT0   6'h10
`define HAT_IDX_OFS_ST1   6'h11
`define HAT_IDX_OFS_ST0   6'h12
`define HAT_IDX_CTRL      6'h20
`define HAT_IDX_STAT      6'h21
`define HAT_IDX_POS_ST    6'h22
`define HAT_IDX_POS_MT    6'h23
`define HAT_CFG_RST       8'h00
`define HAT_RES_RST       8'h40
`define HAT_CTRL_INC_EN   0
`define HAT_CTRL_CLR_MT   1
`define HAT_CLK_KHZ       100000
`define HAT_STEP_MAX_KHZ  14000
`define HAT_STEP_CYC      ((`HAT_CLK_KHZ + `HAT_STEP_MAX_KHZ - 1) / `HAT_STEP_MAX_KHZ)
`define HAT_MT_PERIOD_US  1300
`define HAT_MT_PERIOD_CYC (`HAT_MT_PERIOD_US * (`HAT_CLK_KHZ / 1000))
`define HAT_LAG_LIMIT     16'h4000
`define HAT_HYS_1         16'h001F
`define HAT_HYS_2         16'h0040
`define HAT_HYS_3         16'h007F
`endif

// >>> verilog/hat_pkg.sv
// Types shared by the angle tracking converter.
package hat_pkg;
  typedef enum logic [1:0] {
    HAT_MT_IDLE,
    HAT_MT_REQ,
    HAT_MT_DROP
  } hat_mt_state_t;
  typedef logic [5:0]  hat_idx_t;
  typedef logic [15:0] hat_angle_t;
  typedef logic [31:0] hat_turns_t;
endpackage

// >>> verilog/hat_converter.sv
// Tracking angle converter with offset, multiturn sync and a Wishbone register slave.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "hat_consts.svh"
module hat_converter #(
  parameter int unsigned MT_PERIOD_CYC = `HAT_MT_PERIOD_CYC
) (
  // Clock, reset and enable.
  input  wire logic              I_CLOCK,
  input  wire logic              I_RST_N,
  input  wire logic              I_CE,
  // Wishbone slave.
  input  wire logic              I_WB_CYC,
  input  wire logic              I_WB_STB,
  input  wire logic              I_WB_WE,
  input  wire logic [7:0]        I_WB_ADR,
  input  wire logic [3:0]        I_WB_SEL,
  input  wire logic [31:0]       I_WB_DAT,
  output logic      [31:0]       O_WB_DAT,
  output logic                   O_WB_ACK,
  // Digitised angle from the analog front end.
  input  wire hat_pkg::hat_angle_t I_ANGLE,
  // External multiturn sensor handshake.
  output logic                   O_MT_REQ,
  input  wire logic              I_MT_ACK,
  input  wire logic              I_MT_SYNC,
  input  wire hat_pkg::hat_turns_t I_MT_DATA,
  // Position and status outputs.
  output hat_pkg::hat_angle_t    O_POS_ST,
  output hat_pkg::hat_turns_t    O_POS_MT,
  output logic                   O_LAG_WARNING_N,
  output logic                   O_ERROR_OUT_N,
  output logic                   O_TURN_COUNT_MISMATCH,
  output logic                   O_INCREMENTAL_PORT_A,
  output logic                   O_INCREMENTAL_PORT_B,
  // Analog trims passed to the front end.
  output logic                   O_AMP_CUTOFF_SELECT,
  output logic      [3:0]        O_BIAS_CURRENT_TRIM
);
  import hat_pkg::*;

  function automatic hat_turns_t mt_mask(input logic [2:0] len);
    unique case (len)
      3'h0: mt_mask = 32'h00000000;
      3'h1: mt_mask = 32'h0000000F;
      3'h2: mt_mask = 32'h000000FF;
      3'h3: mt_mask = 32'h00000FFF;
      3'h4: mt_mask = 32'h0000FFFF;
      3'h5: mt_mask = 32'h000FFFFF;
      3'h6: mt_mask = 32'h00FFFFFF;
      3'h7: mt_mask = 32'hFFFFFFFF;
    endcase
  endfunction

  function automatic hat_angle_t hys_lsb(input logic [1:0] code);
    unique case (code)
      2'h0: hys_lsb = 16'h0000;
      2'h1: hys_lsb = `HAT_HYS_1;
      2'h2: hys_lsb = `HAT_HYS_2;
      2'h3: hys_lsb = `HAT_HYS_3;
    endcase
  endfunction

  // Registers.
  logic [7:0]  cfg_q;
  logic [7:0]  res_q;
  logic        cut_q;
  logic [4:0]  harm_q;
  logic [3:0]  bias_q;
  hat_turns_t  ofs_mt_q;
  hat_angle_t  ofs_st_q;
  logic        inc_en_q;
  logic        clr_mt_q;
  logic        ack_q;
  logic [31:0] rdat_q;

  logic [1:0]  hys_c;
  logic        dir_c;
  logic [2:0]  rate_c;
  logic [1:0]  avg_c;
  logic [2:0]  st_c;
  logic [2:0]  mtl_c;
  assign hys_c  = cfg_q[7:6];
  assign dir_c  = cfg_q[5];
  assign rate_c = cfg_q[4:2];
  assign avg_c  = cfg_q[1:0];
  assign st_c   = res_q[6:4];
  assign mtl_c  = res_q[2:0];

  // Input synchronisers.
  hat_angle_t  ang_m_q;
  hat_angle_t  ang_s_q;
  logic [33:0] mt_m_q;
  logic [33:0] mt_s_q;

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      ang_m_q <= 16'h0000;
      ang_s_q <= 16'h0000;
      mt_m_q  <= 34'h000000000;
      mt_s_q  <= 34'h000000000;
    end
    else if (I_CE)
    begin
      ang_m_q <= I_ANGLE;
      ang_s_q <= ang_m_q;
      mt_m_q  <= {I_MT_ACK, I_MT_SYNC, I_MT_DATA};
      mt_s_q  <= mt_m_q;
    end
  end

  // Wishbone slave: answer one cycle after the request is seen.
  logic        wb_req;
  hat_idx_t    idx;
  assign wb_req = I_WB_CYC & I_WB_STB & ~ack_q;
  assign idx    = I_WB_ADR[7:2];
  assign O_WB_ACK = ack_q;
  assign O_WB_DAT = rdat_q;

  logic        wr;
  assign wr = wb_req & I_WB_WE & I_WB_SEL[0];

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      cfg_q    <= `HAT_CFG_RST;
      res_q    <= `HAT_RES_RST;
      cut_q    <= 1'b0;
      harm_q   <= 5'h00;
      bias_q   <= 4'h0;
      ofs_mt_q <= 32'h00000000;
      ofs_st_q <= 16'h0000;
      inc_en_q <= 1'b0;
      clr_mt_q <= 1'b0;
    end
    else if (I_CE)
    begin
      clr_mt_q <= wr && idx == `HAT_IDX_CTRL && I_WB_DAT[`HAT_CTRL_CLR_MT];
      if (wr)
      begin
        unique case (idx)
          `HAT_IDX_CFG:     cfg_q <= I_WB_DAT[7:0];
          `HAT_IDX_RES:     res_q <= {1'b0, I_WB_DAT[6:4], 1'b0, I_WB_DAT[2:0]};
          `HAT_IDX_CUT:     cut_q <= I_WB_DAT[7];
          `HAT_IDX_HRM_HI:  harm_q[4] <= I_WB_DAT[7];
          `HAT_IDX_HRM_LO:
          begin
            harm_q[3:0] <= I_WB_DAT[7:4];
            bias_q      <= I_WB_DAT[3:0];
          end
          // Offset bytes, most significant first.
          `HAT_IDX_OFS_MT3: ofs_mt_q[31:24] <= I_WB_DAT[7:0];
          `HAT_IDX_OFS_MT2: ofs_mt_q[23:16] <= I_WB_DAT[7:0];
          `HAT_IDX_OFS_MT1: ofs_mt_q[15:8]  <= I_WB_DAT[7:0];
          `HAT_IDX_OFS_MT0: ofs_mt_q[7:0]   <= I_WB_DAT[7:0];
          `HAT_IDX_OFS_ST1: ofs_st_q[15:8]  <= I_WB_DAT[7:0];
          `HAT_IDX_OFS_ST0: ofs_st_q[7:0]   <= I_WB_DAT[7:0];
          `HAT_IDX_CTRL:    inc_en_q <= I_WB_DAT[`HAT_CTRL_INC_EN];
          default:          ;
        endcase
      end
    end
  end

  assign O_AMP_CUTOFF_SELECT = cut_q;
  assign O_BIAS_CURRENT_TRIM = bias_q;

  // Converter state.
  hat_angle_t  pos_q;
  hat_angle_t  flt_q;
  logic        up_q;
  logic        lag_q;
  hat_turns_t  mt_q;
  logic        mismatch_q;

  logic [31:0] rd_c;
  always_comb
  begin
    rd_c = 32'h00000000;
    unique case (idx)
      `HAT_IDX_CFG:     rd_c[7:0] = cfg_q;
      `HAT_IDX_RES:     rd_c[7:0] = res_q;
      `HAT_IDX_CUT:     rd_c[7] = cut_q;
      `HAT_IDX_HRM_HI:  rd_c[7] = harm_q[4];
      `HAT_IDX_HRM_LO:  rd_c[7:0] = {harm_q[3:0], bias_q};
      `HAT_IDX_OFS_MT3: rd_c[7:0] = ofs_mt_q[31:24];
      `HAT_IDX_OFS_MT2: rd_c[7:0] = ofs_mt_q[23:16];
      `HAT_IDX_OFS_MT1: rd_c[7:0] = ofs_mt_q[15:8];
      `HAT_IDX_OFS_MT0: rd_c[7:0] = ofs_mt_q[7:0];
      `HAT_IDX_OFS_ST1: rd_c[7:0] = ofs_st_q[15:8];
      `HAT_IDX_OFS_ST0: rd_c[7:0] = ofs_st_q[7:0];
      `HAT_IDX_CTRL:    rd_c[0] = inc_en_q;
      `HAT_IDX_STAT:    rd_c[1:0] = {mismatch_q, lag_q};
      `HAT_IDX_POS_ST:  rd_c[15:0] = O_POS_ST;
      `HAT_IDX_POS_MT:  rd_c = O_POS_MT;
      default:          rd_c = 32'h00000000;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end
    else if (I_CE)
    begin
      ack_q <= wb_req;
      if (wb_req && !I_WB_WE)
      begin
        rdat_q <= rd_c;
      end
    end
  end

  // Step timer: one tracking step per (divider + 1) base periods.
  logic [7:0]  tick_cnt_q;
  logic        tick;
  logic [7:0]  tick_lim;
  assign tick_lim = 8'(({5'h00, rate_c} + 8'h01) * 8'(`HAT_STEP_CYC) - 8'h01);
  assign tick = tick_cnt_q >= tick_lim;

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      tick_cnt_q <= 8'h00;
    end
    else if (I_CE)
    begin
      tick_cnt_q <= tick ? 8'h00 : tick_cnt_q + 8'h01;
    end
  end

  // Target angle: direction, fourth harmonic trim, then averaging.
  hat_angle_t  tgt_raw;
  hat_angle_t  tgt;
  hat_angle_t  diff;
  hat_angle_t  err;
  hat_angle_t  mag;
  hat_angle_t  step;
  logic        trim_neg;
  assign tgt_raw  = dir_c ? 16'h0000 - ang_s_q : ang_s_q;
  assign trim_neg = harm_q[4] ^ tgt_raw[13];
  assign tgt = trim_neg ? tgt_raw - {12'h000, harm_q[3:0]}
                        : tgt_raw + {12'h000, harm_q[3:0]};
  assign diff = tgt - flt_q;
  assign err  = flt_q - pos_q;
  assign mag  = err[15] ? 16'h0000 - err : err;
  assign step = 16'h0001 << st_c;

  logic        lag_c;
  logic        want_up;
  logic        may_move;
  logic [16:0] pos_up;
  logic [16:0] pos_dn;
  assign lag_c    = mag > `HAT_LAG_LIMIT;
  assign want_up  = ~err[15];
  assign may_move = mag >= step && (want_up == up_q || mag >= step + hys_lsb(hys_c));
  assign pos_up   = {1'b0, pos_q} + {1'b0, step};
  assign pos_dn   = {1'b0, pos_q} - {1'b0, step};

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      flt_q <= 16'h0000;
    end
    else if (I_CE && tick)
    begin
      if (avg_c == 2'h0)
      begin
        flt_q <= tgt;
      end
      else
      begin
        flt_q <= flt_q + 16'($signed(diff) >>> avg_c);
      end
    end
  end

  // Multiturn read-in.
  hat_mt_state_t mt_st_q;
  logic [31:0] mt_tmr_q;
  logic        mt_load_q;
  hat_turns_t  mt_new_q;
  logic        mt_first_q;
  hat_turns_t  aligned;
  logic        mt_ack_s;
  assign mt_ack_s = mt_s_q[33];
  assign aligned  = (!mt_s_q[32] && pos_q[15]) ? mt_s_q[31:0] - 32'h00000001
                                               : mt_s_q[31:0];

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      mt_st_q    <= HAT_MT_REQ;
      mt_tmr_q   <= 32'h00000000;
      mt_load_q  <= 1'b0;
      mt_new_q   <= 32'h00000000;
      mt_first_q <= 1'b1;
      O_MT_REQ   <= 1'b0;
    end
    else if (I_CE)
    begin
      mt_load_q <= 1'b0;
      unique case (mt_st_q)
        HAT_MT_IDLE:
        begin
          mt_tmr_q <= mt_tmr_q + 32'h00000001;
          if (mtl_c != 3'h0 && mt_tmr_q >= MT_PERIOD_CYC - 1)
          begin
            mt_tmr_q <= 32'h00000000;
            mt_st_q  <= HAT_MT_REQ;
          end
        end
        HAT_MT_REQ:
        begin
          O_MT_REQ <= mtl_c != 3'h0;
          if (mt_ack_s && O_MT_REQ)
          begin
            O_MT_REQ  <= 1'b0;
            mt_new_q  <= aligned & mt_mask(mtl_c);
            mt_load_q <= 1'b1;
            mt_st_q   <= HAT_MT_DROP;
          end
        end
        HAT_MT_DROP:
        begin
          if (!mt_ack_s)
          begin
            mt_first_q <= 1'b0;
            mt_st_q    <= HAT_MT_IDLE;
          end
        end
      endcase
    end
  end

  // Mismatch flag: a set in the clearing cycle wins.
  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      mismatch_q <= 1'b0;
    end
    else if (I_CE)
    begin
      if (mt_load_q && !mt_first_q && mt_new_q != (mt_q & mt_mask(mtl_c)))
      begin
        mismatch_q <= 1'b1;
      end
      else if (clr_mt_q)
      begin
        mismatch_q <= 1'b0;
      end
    end
  end

  // Tracking loop and internal turn counter.
  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      pos_q <= 16'h0000;
      up_q  <= 1'b1;
      lag_q <= 1'b0;
      mt_q  <= 32'h00000000;
    end
    else if (I_CE)
    begin
      if (mt_load_q)
      begin
        mt_q <= mt_new_q;
      end
      if (tick)
      begin
        lag_q <= lag_c;
        if (lag_c)
        begin
          pos_q <= flt_q & ~(step - 16'h0001);
        end
        else if (may_move)
        begin
          up_q <= want_up;
          if (want_up)
          begin
            pos_q <= pos_up[15:0];
            if (pos_up[16] && !mt_load_q)
            begin
              mt_q <= mt_q + 32'h00000001;
            end
          end
          else
          begin
            pos_q <= pos_dn[15:0];
            if (pos_dn[16] && !mt_load_q)
            begin
              mt_q <= mt_q - 32'h00000001;
            end
          end
        end
      end
    end
  end

  // Output position with zero offset.
  hat_angle_t  ofs_sc;
  logic [16:0] sum_st;
  hat_turns_t  sum_mt;
  assign ofs_sc = (ofs_st_q & ~(16'hFFFF << (5'd16 - {2'b00, st_c}))) << st_c;
  assign sum_st = {1'b0, pos_q} + {1'b0, ofs_sc};
  assign sum_mt = mt_q + ofs_mt_q + {31'h00000000, sum_st[16]};

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_POS_ST <= 16'h0000;
      O_POS_MT <= 32'h00000000;
    end
    else if (I_CE)
    begin
      O_POS_ST <= sum_st[15:0] >> st_c;
      O_POS_MT <= sum_mt & mt_mask(mtl_c);
    end
  end

  // Quadrature outputs follow the two lowest bits of the tracked position at output resolution, without the offset, so edges are one step apart.
  hat_angle_t  q_pos;
  assign q_pos = pos_q >> st_c;

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_INCREMENTAL_PORT_A <= 1'b0;
      O_INCREMENTAL_PORT_B <= 1'b0;
      O_LAG_WARNING_N      <= 1'b1;
      O_ERROR_OUT_N        <= 1'b1;
      O_TURN_COUNT_MISMATCH <= 1'b0;
    end
    else if (I_CE)
    begin
      O_INCREMENTAL_PORT_A <= q_pos[1];
      O_INCREMENTAL_PORT_B <= q_pos[1] ^ q_pos[0];
      O_LAG_WARNING_N      <= ~lag_q;
      O_ERROR_OUT_N        <= ~(inc_en_q & lag_q);
      O_TURN_COUNT_MISMATCH <= mismatch_q;
    end
  end

endmodule

// >>> verif/hat_converter_properties.sv
// Port-level assertions for the angle tracking converter.
`timescale 1ns/1ps
module hat_converter_checker #(
  parameter int unsigned MT_PERIOD_CYC = 200
) (
  // Clock, reset and bus.
  input wire logic                I_CLOCK,
  input wire logic                I_RST_N,
  input wire logic                I_CE,
  input wire logic                I_WB_CYC,
  input wire logic                I_WB_STB,
  input wire logic                O_WB_ACK,
  // Turn-count link.
  input wire logic                O_MT_REQ,
  input wire logic                I_MT_ACK,
  // Position and status.
  input wire hat_pkg::hat_angle_t O_POS_ST,
  input wire logic                O_LAG_WARNING_N,
  input wire logic                O_ERROR_OUT_N,
  input wire logic                O_TURN_COUNT_MISMATCH,
  input wire logic                O_INCREMENTAL_PORT_A,
  input wire logic                O_INCREMENTAL_PORT_B
);
  import hat_pkg::*;
  logic [3:0]  calm_q;
  logic [31:0] gap_q;
  logic        quiet;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  // Bus writes and phase steps move the position legally, so step checks wait for calm.
  always_ff @(posedge I_CLOCK or negedge I_RST_N)
    if (!I_RST_N)
      calm_q <= 4'h0;
    else if (O_WB_ACK || !O_LAG_WARNING_N)
      calm_q <= 4'h0;
    else if (calm_q != 4'hF)
      calm_q <= calm_q + 4'h1;
  always_ff @(posedge I_CLOCK or negedge I_RST_N)
    if (!I_RST_N)
      gap_q <= MT_PERIOD_CYC;
    else if (O_MT_REQ)
      gap_q <= 32'h0;
    else if (gap_q < MT_PERIOD_CYC)
      gap_q <= gap_q + 32'h1;
  assign quiet = calm_q >= 4'h4 && !O_WB_ACK && O_LAG_WARNING_N;
  a_ack_answers: assert property (I_CE && I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("bus request not acknowledged");
  a_pos_one_lsb: assert property (quiet && $changed(O_POS_ST) && O_POS_ST != 16'h0 && $past(O_POS_ST) != 16'h0
    |-> 16'(O_POS_ST - $past(O_POS_ST)) inside {16'h0001, 16'hFFFF})
    else $error("position moved by more than one step");
  a_error_needs_lag: assert property (!O_ERROR_OUT_N |-> !O_LAG_WARNING_N)
    else $error("error pin low without lag");
  a_quad_gray: assert property (quiet && $changed(O_INCREMENTAL_PORT_A) |-> $stable(O_INCREMENTAL_PORT_B))
    else $error("both quadrature lines moved together");
  a_quad_spacing: assert property (quiet && ($changed(O_INCREMENTAL_PORT_A) || $changed(O_INCREMENTAL_PORT_B))
    |=> (!quiet || ($stable(O_INCREMENTAL_PORT_A) && $stable(O_INCREMENTAL_PORT_B)))[*7])
    else $error("quadrature edges closer than one step period");
  a_mt_req_holds: assert property (O_MT_REQ && !I_MT_ACK |=> O_MT_REQ)
    else $error("turn request withdrawn before answer");
  a_mt_req_drop: assert property ($rose(I_MT_ACK) && O_MT_REQ |-> ##[1:6] !O_MT_REQ)
    else $error("turn request not released after answer");
  a_mt_req_gap: assert property ($rose(O_MT_REQ) |-> gap_q >= MT_PERIOD_CYC)
    else $error("turn requests too close together");
  a_mismatch_sticky: assert property (O_TURN_COUNT_MISMATCH && !I_WB_CYC && !$past(I_WB_CYC)
    |=> O_TURN_COUNT_MISMATCH)
    else $error("mismatch flag dropped by itself");
endmodule
bind hat_converter hat_converter_checker #(.MT_PERIOD_CYC(MT_PERIOD_CYC)) u_chk (.I_CLOCK(I_CLOCK),
  .I_RST_N(I_RST_N), .I_CE(I_CE), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .O_WB_ACK(O_WB_ACK),
  .O_MT_REQ(O_MT_REQ), .I_MT_ACK(I_MT_ACK), .O_POS_ST(O_POS_ST), .O_LAG_WARNING_N(O_LAG_WARNING_N),
  .O_ERROR_OUT_N(O_ERROR_OUT_N), .O_TURN_COUNT_MISMATCH(O_TURN_COUNT_MISMATCH),
  .O_INCREMENTAL_PORT_A(O_INCREMENTAL_PORT_A), .O_INCREMENTAL_PORT_B(O_INCREMENTAL_PORT_B));

// >>> verif/hat_mt_sensor.sv
// Behavioural external turn-count sensor that answers the converter's requests.
`timescale 1ns/1ps
module hat_mt_sensor (
  // Clock and reset.
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // Request and answer.
  input  wire logic        i_req,
  output logic             o_ack,
  output logic             o_sync,
  output logic [31:0]      o_data,
  // Value, sync bit and answer delay chosen by the bench.
  input  wire logic [31:0] i_turns,
  input  wire logic        i_sync,
  input  wire logic [3:0]  i_delay
);
  logic [3:0] wait_q;
  // Data is only valid while ack is high; otherwise it keeps changing so stale values are never trusted.
  always_ff @(posedge i_clock or negedge i_rst_n)
    if (!i_rst_n)
    begin
      o_ack  <= 1'b0;
      o_sync <= 1'b0;
      o_data <= 32'h0;
      wait_q <= 4'h0;
    end
    else if (o_ack)
    begin
      if (!i_req)
      begin
        o_ack  <= 1'b0;
        wait_q <= 4'h0;
      end
    end
    else if (i_req && wait_q >= i_delay)
    begin
      o_ack  <= 1'b1;
      o_sync <= i_sync;
      o_data <= i_turns;
    end
    else
    begin
      o_sync <= ~o_sync;
      o_data <= ~o_data;
      if (i_req)
        wait_q <= wait_q + 4'h1;
    end
endmodule

// >>> verif/hat_converter_bench.sv
// Self-checking bench for the angle tracking converter.
`timescale 1ns/1ps
module hat_converter_bench;
  import hat_pkg::*;
  logic        clock;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] wb_dat;
  logic        ack;
  hat_angle_t  ang;
  logic        mt_req;
  logic        mt_ack;
  logic        mt_sync;
  hat_turns_t  mt_data;
  hat_angle_t  pos_st;
  hat_turns_t  pos_mt;
  logic        warn_n;
  logic        err_n;
  logic        mism;
  logic        cut;
  logic [3:0]  bias;
  logic [31:0] turns;
  logic        sn_sync;
  logic [3:0]  sn_delay;
  logic [31:0] rdat;
  int          checks;
  int          mismatches;
  logic [31:0] masks [8] = '{32'h0, 32'hF, 32'hFF, 32'hFFF, 32'hFFFF, 32'hF_FFFF, 32'hFF_FFFF, 32'hFFFF_FFFF};
  hat_converter #(.MT_PERIOD_CYC(200)) dut (.I_CLOCK(clock), .I_RST_N(rst_n), .I_CE(1'b1), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_DAT(wb_dat),
    .O_WB_ACK(ack), .I_ANGLE(ang), .O_MT_REQ(mt_req), .I_MT_ACK(mt_ack), .I_MT_SYNC(mt_sync),
    .I_MT_DATA(mt_data), .O_POS_ST(pos_st), .O_POS_MT(pos_mt), .O_LAG_WARNING_N(warn_n),
    .O_ERROR_OUT_N(err_n), .O_TURN_COUNT_MISMATCH(mism), .O_INCREMENTAL_PORT_A(),
    .O_INCREMENTAL_PORT_B(), .O_AMP_CUTOFF_SELECT(cut), .O_BIAS_CURRENT_TRIM(bias));
  hat_mt_sensor u_sensor (.i_clock(clock), .i_rst_n(rst_n), .i_req(mt_req), .o_ack(mt_ack), .o_sync(mt_sync),
    .o_data(mt_data), .i_turns(turns), .i_sync(sn_sync), .i_delay(sn_delay));
  always #5 clock = ~clock;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic wb(input logic w, input hat_idx_t idx, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do
    begin
      @(posedge clock);
      k++;
    end
    while (ack !== 1'b1);
    check(32'(ack), 32'h1);
    rdat = wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input hat_idx_t idx, input logic [31:0] exp);
    wb(1'b0, idx, 8'h00);
    check(rdat, exp);
  endtask
  task automatic watch_lag(input logic inc);
    logic seen;
    logic low;
    seen = 1'b0;
    low = 1'b0;
    repeat (60)
    begin
      @(posedge clock);
      seen |= (warn_n === 1'b0);
      low |= (err_n === 1'b0);
    end
    check(32'(seen), 32'h1);
    check(32'(low), 32'(inc));
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge clock);
    mismatches++;
    conclude();
  end
  initial
  begin
    clock = 1'b0;
    rst_n = 1'b0;
    {cyc, stb, we, adr, wdat} = '0;
    ang = 16'h1234;
    turns = 32'h7654_3100;
    sn_sync = 1'b1;
    sn_delay = 4'h0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(6'h00, 32'h00);
    rd(6'h01, 32'h40);
    wb(1'b1, 6'h3F, 8'hFF);
    rd(6'h3F, 32'h00);
    wb(1'b1, 6'h04, 8'h80);
    wb(1'b1, 6'h05, 8'h80);
    wb(1'b1, 6'h06, 8'hA5);
    rd(6'h05, 32'h80);
    rd(6'h06, 32'hA5);
    check(32'(cut), 32'h1);
    check(32'(bias), 32'h5);
    wb(1'b1, 6'h06, 8'h05);
    for (int i = 0; i < 8; i++)
    begin
      wb(1'b1, 6'h00, {i[1:0], i[0], i[2:0], i[1:0]});
      rd(6'h00, {24'h0, i[1:0], i[0], i[2:0], i[1:0]});
    end
    wb(1'b1, 6'h00, 8'h00);
    wait_cyc(3000);
    check(32'(pos_st), 32'h123);
    for (int r = 0; r < 8; r += 7)
    begin
      wb(1'b1, 6'h00, 8'(r << 2));
      ang <= ang + 16'h0080;
      wait_cyc(32 * (r + 1));
      check(32'(pos_st == {4'h0, ang[15:4]}), 32'h0);
      wait_cyc(48 * (r + 1) + 40);
      check(32'(pos_st), 32'(ang[15:4]));
    end
    for (int c = 7; c >= 0; c--)
    begin
      wb(1'b1, 6'h00, (c < 4) ? 8'h01 : 8'h00);
      wb(1'b1, 6'h01, 8'(c << 4));
      wait_cyc(800);
      check(32'(pos_st), 32'(ang >> c));
    end
    wb(1'b1, 6'h10, 8'h05);
    wb(1'b1, 6'h11, 8'hF0);
    wb(1'b1, 6'h01, 8'h07);
    wait_cyc(600);
    check(32'(pos_st), 32'h0334);
    for (int m = 7; m >= 0; m--)
    begin
      wb(1'b1, 6'h01, 8'(m));
      wait_cyc(10);
      check(pos_mt, 32'h7654_3106 & masks[m]);
    end
    // Back to 12 bits so averaging may be switched off and the phase step lands on the target.
    wb(1'b1, 6'h01, 8'h47);
    wb(1'b1, 6'h00, 8'h00);
    sn_delay <= 4'h9;
    wait_cyc(300);
    wb(1'b1, 6'h20, 8'h03);
    wait_cyc(5);
    check(32'(mism), 32'h0);
    ang <= 16'h9334;
    watch_lag(1'b1);
    wait_cyc(400);
    check(32'(pos_st), 32'h0933);
    check(pos_mt, 32'h7654_3105);
    sn_sync <= 1'b0;
    wait_cyc(400);
    check(32'(mism), 32'h1);
    check(pos_mt, 32'h7654_3104);
    rd(6'h21, 32'h2);
    wb(1'b1, 6'h20, 8'h02);
    wait_cyc(400);
    check(32'(mism), 32'h0);
    ang <= 16'h1334;
    watch_lag(1'b0);
    conclude();
  end
endmodule
